/* File: verification/fpc_console_asserts.sv */
module fpc_console_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        run_stop_halt,
  input wire        one_transfer_step,
  input wire        power_lock,
  input wire        cpu_running,
  input wire        sys_clear,
  input wire        cpu_start,
  input wire        cpu_resume,
  input wire        cpu_step_inst,
  input wire        cpu_step_bus,
  input wire        dma_grant_transfers,
  input wire        mmu_req,
  input wire        mem_req,
  input wire        mem_ack,
  input wire [21:0] mem_addr,
  input wire        reg_req,
  input wire        addressing_fault_lamp,
  input wire        parity_fault_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // run control
  start_seq_a: assert property (cpu_start |-> $past(sys_clear))
    else $error("start without preceding clear");
  // lever compared four cycles back to cover the input synchronisers
  halt_start_a: assert property (sys_clear && run_stop_halt
    && $past(run_stop_halt, 4) |=> !cpu_start) else $error("start at halt began a run");
  run_ignore_a: assert property ($past(cpu_running, 2) && $past(cpu_running)
    |-> !cpu_resume && !cpu_start && !sys_clear) else $error("key acted while running");
  resume_lever_a: assert property (cpu_resume |-> !run_stop_halt)
    else $error("resume issued at halt");
  step_kind_a: assert property (cpu_step_inst || cpu_step_bus
    |-> run_stop_halt && cpu_step_bus == one_transfer_step) else $error("wrong step kind");
  dma_grant_a: assert property ($past(run_stop_halt, 4) == run_stop_halt
    && $past(one_transfer_step, 4) == one_transfer_step
    |-> dma_grant_transfers == !(run_stop_halt && one_transfer_step)) else $error("dma grant");
  // ==========================================================
  // console accesses
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped early");
  greg_route_a: assert property (mem_req |-> mem_addr[21:4] != 18'h3_FFFC)
    else $error("register address on memory port");
  fault_block_a: assert property (addressing_fault_lamp || parity_fault_lamp
    |-> !$rose(mem_req) && !$rose(mmu_req) && !$rose(reg_req)) else $error("access after fault");
  bus_step_keys_a: assert property (one_transfer_step && $past(one_transfer_step, 8)
    |-> !$rose(mem_req) && !$rose(reg_req)) else $error("access in bus step mode");
  lock_keys_a: assert property (power_lock && $past(power_lock, 8)
    |-> !sys_clear && !cpu_resume && !$rose(mem_req)) else $error("key acted while locked");
  cover property (cpu_start);
  cover property (reg_req && !mem_req);
  cover property (cpu_step_bus);
  cover property (addressing_fault_lamp);
endmodule // fpc_console_asserts

bind fpc_console fpc_console_asserts u_chk (.*);

/* File: verification/fpc_console_tb.sv */
module fpc_console_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, pbusy, addressing_fault_lamp, parity_fault_lamp;
  logic        run_stop_halt = 0, one_transfer_step = 0, power_lock = 0, cpu_running = 0;
  logic [21:0] switch_reg = 0, mmu_paddr = 0;
  logic [2:0]  addr_select = 3'h7, ksel = 0;
  wire  [4:0]  keys;
  wire  [21:0] addr_display, cpu_start_addr, mem_addr;
  wire  [15:0] data_display, mmu_vaddr, mem_wdata, reg_wdata;
  wire         cpu_halt_req, sys_clear, cpu_start, cpu_resume, cpu_step_inst, cpu_step_bus;
  wire         dma_grant_transfers, mmu_req, mem_req, mem_wr, reg_req, reg_wr;
  wire  [2:0]  mmu_mode_space;
  wire  [3:0]  reg_index;
  logic        mmu_ack = 0, mmu_fault = 0, mem_ack = 0, mem_addr_fault = 0;
  logic        mem_parity_fault = 0, reg_ack = 0;
  logic [15:0] mem_rdata = 0, reg_rdata = 0, lf = 16'd6639, d;
  logic [1:0]  dly = 0;
  logic [47:0] q[$];
  int          err_count = 0, check_count = 0;

  fpc_console #(.DEB_CYC(4)) dut (.address_load_key(keys[0]), .read_location_key(keys[1]),
    .write_location_key(keys[2]), .resume_key(keys[3]), .start_key(keys[4]), .*);
  fpc_panel_model panel (.pclk(pclk), .go(go), .ksel(ksel), .keys(keys), .busy(pbusy));

  initial forever #5 pclk = ~pclk;

  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // event note: kind, address, data
  function automatic [47:0] ev(input [3:0] k, input [21:0] a, input [15:0] x);
    ev = {k, 6'h0, a, x};
  endfunction
  task automatic chk(input [47:0] got, input [47:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task ex(input [47:0] v);
    q.push_back(v);
  endtask
  // ==========================================================
  // apb master: holds the request until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic e, input logic [31:0] x);
    ex({4'hE, e, 11'h0, x});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task pk(input logic [2:0] k);
    go <= 1'b1;
    ksel <= k;
    @(posedge pclk);
    go <= 1'b0;
    while (pbusy) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask
  // ==========================================================
  // far side responders; memory latency is random
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    mmu_ack <= 1'b0;
    reg_ack <= 1'b0;
    if (mmu_req && !mmu_ack) begin
      mmu_ack <= 1'b1;
      mmu_paddr <= {6'h05, mmu_vaddr};
      mmu_fault <= mmu_vaddr[15:12] == 4'hF;
    end
    if (reg_req && !reg_ack) begin
      reg_ack <= 1'b1;
      reg_rdata <= {12'hA00, reg_index};
    end
    if (mem_req && !mem_ack && dly == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr[15:0] ^ 16'h5A5A;
      mem_addr_fault <= mem_addr[21:16] == 6'h3E;
      mem_parity_fault <= mem_addr[21:16] == 6'h3D;
      lf <= lfsr(lf);
      dly <= lf[1:0];
    end else if (mem_req && !mem_ack)
      dly <= dly - 2'h1;
  end
  // ==========================================================
  // monitor: every result takes the oldest note; no note means unexpected
  task see(input [47:0] v);
    chk(v, q.size() > 0 ? q.pop_front() : ~v);
  endtask
  always @(posedge pclk) begin
    if (mem_req && mem_ack) see(ev(mem_wr ? 4'h2 : 4'h1, mem_addr, mem_wr ? mem_wdata : 16'h0));
    if (reg_req && reg_ack)
      see(ev(reg_wr ? 4'h4 : 4'h3, {18'h0, reg_index}, reg_wr ? reg_wdata : 16'h0));
    if (mmu_req && mmu_ack) see(ev(4'h9, {6'h0, mmu_vaddr}, {13'h0, mmu_mode_space}));
    if (cpu_resume) see(ev(4'h5, 22'h0, 16'h0));
    if (cpu_step_inst) see(ev(4'h6, 22'h0, 16'h0));
    if (cpu_step_bus) see(ev(4'h7, 22'h0, 16'h0));
    if (sys_clear) see(ev(4'h8, 22'h0, 16'h0));
    if (cpu_start) see(ev(4'hA, cpu_start_addr, 16'h0));
    if (psel && penable && pready && !pwrite)
      see({4'hE, pslverr, 11'h0, pslverr ? 32'h0 : prdata});
  end
  initial begin
    #300000;
    err_count++;
    stop_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004, 1'b0, 32'h0000_0000);
    rd(12'h010, 1'b1, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rd(12'h000, 1'b0, 32'h0000_0001);
    pk(3'h4);
    apb(1'b1, 12'h000, 32'h0000_0000);
    run_stop_halt <= 1'b1;
    switch_reg <= 22'h01_2340;
    pk(3'h0);
    chk(48'(cpu_halt_req), 48'h1);
    rd(12'h008, 1'b0, 32'h0001_2340);
    ex(ev(4'h8, 22'h0, 16'h0));
    pk(3'h4);
    ex(ev(4'h1, 22'h01_2340, 16'h0));
    pk(3'h1);
    chk(48'(data_display), 48'h791A);
    ex(ev(4'h1, 22'h01_2342, 16'h0));
    pk(3'h1);
    chk(48'(addr_display), 48'h01_2342);
    switch_reg <= 22'h00_BEEF;
    ex(ev(4'h2, 22'h01_2342, 16'hBEEF));
    pk(3'h2);
    chk(48'(data_display), 48'hBEEF);
    d = lf;
    switch_reg <= {6'h0, d};
    ex(ev(4'h2, 22'h01_2344, d));
    pk(3'h2);
    ex(ev(4'h1, 22'h01_2344, 16'h0));
    pk(3'h1);
    switch_reg <= 22'h01_FFFE;
    pk(3'h0);
    ex(ev(4'h1, 22'h01_FFFE, 16'h0));
    ex(ev(4'h1, 22'h01_0000, 16'h0));
    pk(3'h1);
    pk(3'h1);
    switch_reg <= 22'h3F_FFBE;
    pk(3'h0);
    ex(ev(4'h1, 22'h3F_FFBE, 16'h0));
    ex(ev(4'h1, 22'h3F_0000, 16'h0));
    pk(3'h1);
    pk(3'h1);
    switch_reg <= 22'h3F_FFCF;
    pk(3'h0);
    ex(ev(4'h3, 22'hF, 16'h0));
    ex(ev(4'h3, 22'h0, 16'h0));
    pk(3'h1);
    pk(3'h1);
    addr_select <= 3'h2;
    ex(ev(4'h3, 22'h1, 16'h0));
    ex(ev(4'h4, 22'h1, 16'hFFCF));
    pk(3'h1);
    chk(48'(addr_display), 48'h3F_FFC1);
    pk(3'h2);
    rd(12'h004, 1'b0, 32'h0000_0058);
    addr_select <= 3'h3;
    switch_reg <= 22'h3F_1234;
    pk(3'h0);
    ex(ev(4'h9, 22'h1234, 16'h3));
    ex(ev(4'h1, 22'h05_1234, 16'h0));
    pk(3'h1);
    addr_select <= 3'h6;
    repeat (5) @(posedge pclk);
    chk(48'(addr_display), 48'h05_1234);
    addr_select <= 3'h3;
    switch_reg <= 22'h00_F000;
    pk(3'h0);
    ex(ev(4'h9, 22'hF000, 16'h3));
    pk(3'h1);
    chk(48'(addressing_fault_lamp), 48'h1);
    addr_select <= 3'h7;
    switch_reg <= 22'h3E_0000;
    pk(3'h0);
    ex(ev(4'h1, 22'h3E_0000, 16'h0));
    pk(3'h1);
    chk(48'(addressing_fault_lamp), 48'h1);
    pk(3'h1);
    pk(3'h2);
    switch_reg <= 22'h3D_0000;
    pk(3'h0);
    ex(ev(4'h1, 22'h3D_0000, 16'h0));
    pk(3'h1);
    chk(48'(parity_fault_lamp), 48'h1);
    switch_reg <= 22'h00_0100;
    pk(3'h0);
    chk(48'(addressing_fault_lamp), 48'h0);
    chk(48'(parity_fault_lamp), 48'h0);
    ex(ev(4'h1, 22'h00_0100, 16'h0));
    pk(3'h1);
    one_transfer_step <= 1'b1;
    pk(3'h0);
    pk(3'h1);
    chk(48'(dma_grant_transfers), 48'h0);
    ex(ev(4'h7, 22'h0, 16'h0));
    pk(3'h3);
    one_transfer_step <= 1'b0;
    ex(ev(4'h6, 22'h0, 16'h0));
    pk(3'h3);
    chk(48'(dma_grant_transfers), 48'h1);
    run_stop_halt <= 1'b0;
    ex(ev(4'h5, 22'h0, 16'h0));
    pk(3'h3);
    cpu_running <= 1'b1;
    pk(3'h3);
    pk(3'h4);
    cpu_running <= 1'b0;
    switch_reg <= 22'h00_1000;
    pk(3'h0);
    ex(ev(4'h8, 22'h0, 16'h0));
    ex(ev(4'hA, 22'h00_1000, 16'h0));
    pk(3'h4);
    power_lock <= 1'b1;
    pk(3'h4);
    pk(3'h3);
    power_lock <= 1'b0;
    chk(48'(q.size()), 48'h0);
    stop_test;
  end
endmodule // fpc_console_tb

/* File: verification/fpc_panel_model.sv */
module fpc_panel_model (
  input  wire        pclk,
  input  wire        go,
  input  wire  [2:0] ksel,
  output logic [4:0] keys,
  output logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int         n = 0;
  logic [2:0] k = 3'h0;
  // one press: contact bounce, long hold, long release
  always @(posedge pclk) begin
    if (go) begin
      n <= 30;
      k <= ksel;
    end else if (n > 0)
      n <= n - 1;
  end
  // the dip at 27 is the bounce the debouncer must swallow
  assign keys = (n > 15 && n != 27) ? (5'h01 << k) : 5'h00;
  assign busy = go || n != 0;
endmodule // fpc_panel_model

/* File: verilog/fpc_console.v */
`include "fpc_consts.vh"
module fpc_console #(
  parameter NKEY     = 5,
  parameter DEB_CYC  = `FPC_DEBOUNCE_US * `FPC_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        address_load_key,
  input  wire        read_location_key,
  input  wire        write_location_key,
  input  wire        resume_key,
  input  wire        start_key,
  input  wire        run_stop_halt,
  input  wire        one_transfer_step,
  input  wire        power_lock,
  input  wire [21:0] switch_reg,
  input  wire [2:0]  addr_select,
  output reg  [21:0] addr_display,
  output reg  [15:0] data_display,
  output reg         addressing_fault_lamp,
  output reg         parity_fault_lamp,
  input  wire        cpu_running,
  output reg         cpu_halt_req,
  output reg         sys_clear,
  output reg         cpu_start,
  output reg  [21:0] cpu_start_addr,
  output reg         cpu_resume,
  output reg         cpu_step_inst,
  output reg         cpu_step_bus,
  output reg         dma_grant_transfers,
  output reg         mmu_req,
  output reg  [15:0] mmu_vaddr,
  output reg  [2:0]  mmu_mode_space,
  input  wire        mmu_ack,
  input  wire [21:0] mmu_paddr,
  input  wire        mmu_fault,
  output reg         mem_req,
  output reg         mem_wr,
  output reg  [21:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata,
  input  wire        mem_addr_fault,
  input  wire        mem_parity_fault,
  output reg         reg_req,
  output reg         reg_wr,
  output reg  [3:0]  reg_index,
  output reg  [15:0] reg_wdata,
  input  wire        reg_ack,
  input  wire [15:0] reg_rdata
);

  // ==========================================================
  // states
  localparam S_IDLE  = 3'd0;
  localparam S_START = 3'd1;
  localparam S_MMU   = 3'd2;
  localparam S_MEM   = 3'd3;
  localparam S_REG   = 3'd4;

  localparam K_LOAD = 0;
  localparam K_READ = 1;
  localparam K_WRT  = 2;
  localparam K_RES  = 3;
  localparam K_STA  = 4;

  // true when a full address falls in the general register window
  function is_greg;
    input [21:0] a;
    begin
      is_greg = (a[21:4] == `FPC_GREG_TAG);
    end
  endfunction

  // ==========================================================
  // panel input synchronisers
  wire [NKEY-1:0] key_raw = {start_key, resume_key, write_location_key,
                             read_location_key, address_load_key};
  reg  [NKEY-1:0] key_s1;
  reg  [NKEY-1:0] key_s2;
  reg  [3:0]      lev_s1;
  reg  [3:0]      lev_s2;
  reg  [21:0]     sw_s1;
  reg  [21:0]     sw_s2;
  reg  [2:0]      sel_s1;
  reg  [2:0]      sel_s2;

  // the first stage is read only by the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1 <= {NKEY{1'b0}};
      key_s2 <= {NKEY{1'b0}};
      lev_s1 <= 4'h0;
      lev_s2 <= 4'h0;
      sw_s1  <= 22'h00_0000;
      sw_s2  <= 22'h00_0000;
      sel_s1 <= 3'h0;
      sel_s2 <= 3'h0;
    end else begin
      key_s1 <= key_raw;
      key_s2 <= key_s1;
      lev_s1 <= {power_lock, one_transfer_step, run_stop_halt, 1'b0};
      lev_s2 <= lev_s1;
      sw_s1  <= switch_reg;
      sw_s2  <= sw_s1;
      sel_s1 <= addr_select;
      sel_s2 <= sel_s1;
    end
  end

  wire halt_lvl = lev_s2[1];
  wire bus_step = lev_s2[2];
  wire locked   = lev_s2[3];

  // ==========================================================
  // debounce and single edge per key
  wire [NKEY-1:0] key_pulse;
  genvar gi;
  generate
    for (gi = 0; gi < NKEY; gi = gi + 1) begin : g_deb
      reg [31:0] cnt;
      reg        stable;
      reg        pulse;
      // one driver per bit: each slice owns its own pulse flop
      assign key_pulse[gi] = pulse;
      // a key must hold its new level for the whole window to count
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt    <= 32'h0000_0000;
          stable <= 1'b0;
          pulse  <= 1'b0;
        end else begin
          pulse <= 1'b0;
          if (key_s2[gi] == stable) begin
            cnt <= 32'h0000_0000;
          end else if (cnt >= DEB_CYC - 1) begin
            cnt    <= 32'h0000_0000;
            stable <= key_s2[gi];
            pulse  <= key_s2[gi];
          end else begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // apb registers and key gating
  reg        keys_off;
  reg [2:0]  state;
  reg [1:0]  last_op;
  reg        last_reg;
  reg        fault;
  reg        cur_wr;
  reg [21:0] addr_reg;
  reg [21:0] xlat_addr;

  wire keys_ok  = !locked && !keys_off;
  wire idle     = (state == S_IDLE);
  wire p_load   = key_pulse[K_LOAD] && keys_ok && idle && !bus_step;
  wire p_read   = key_pulse[K_READ] && keys_ok && idle && !bus_step;
  wire p_write  = key_pulse[K_WRT] && keys_ok && idle && !bus_step;
  wire p_res    = key_pulse[K_RES] && keys_ok && idle;
  wire p_start  = key_pulse[K_STA] && keys_ok && idle;
  wire apb_wr   = psel && penable && pready && pwrite;

  reg [31:0] rd_mux;
  reg        rd_hit;
  // decode for the read data and the unmapped answer
  always @* begin
    rd_mux = `FPC_ZERO32;
    rd_hit = 1'b1;
    case (paddr)
      `FPC_OFF_CTRL:   rd_mux = {31'h0000_0000, keys_off};
      `FPC_OFF_STATUS: rd_mux = {25'h000_0000, halt_lvl, !idle, last_reg,
                                 last_op == `FPC_WRITE, last_op == `FPC_READ,
                                 fault, cpu_running};
      `FPC_OFF_ADDR:   rd_mux = {10'h000, addr_reg};
      `FPC_OFF_DATA:   rd_mux = {16'h0000, data_display};
      default:         rd_hit = 1'b0;
    endcase
  end

  // one wait-free access: ready is registered in the setup cycle and is high in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= `FPC_ZERO32;
      keys_off <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : `FPC_ZERO32;
      if (apb_wr && paddr == `FPC_OFF_CTRL) begin
        keys_off <= pwdata[`FPC_CTRL_KEYOFF];
      end
    end
  end

  // ==========================================================
  // step address calculation
  reg [21:0] step_addr;
  reg [15:0] mem_next;
  always @* begin
    mem_next = addr_reg[15:0] + `FPC_MEM_STEP;
    if (last_reg) begin
      step_addr = {addr_reg[21:4], addr_reg[3:0] + `FPC_GREG_STEP};
    end else if (is_greg({addr_reg[`FPC_BLOCK_HI], mem_next})) begin
      step_addr = {addr_reg[`FPC_BLOCK_HI], 16'h0000};
    end else begin
      step_addr = {addr_reg[`FPC_BLOCK_HI], mem_next};
    end
  end
  // the register step carries only into bit 3, so 717 wraps to 700

  // ==========================================================
  // execution control and console access sequencer
  reg [21:0] acc_addr;
  always @* begin
    acc_addr = addr_reg;
    if ((p_read && last_op == `FPC_READ) ||
        (p_write && last_op == `FPC_WRITE)) begin
      acc_addr = step_addr;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                 <= S_IDLE;
      last_op               <= `FPC_NONE;
      last_reg              <= 1'b0;
      fault                 <= 1'b0;
      cur_wr                <= 1'b0;
      addr_reg              <= 22'h00_0000;
      xlat_addr             <= 22'h00_0000;
      addr_display          <= 22'h00_0000;
      data_display          <= 16'h0000;
      addressing_fault_lamp <= 1'b0;
      parity_fault_lamp     <= 1'b0;
      cpu_halt_req          <= 1'b0;
      sys_clear             <= 1'b0;
      cpu_start             <= 1'b0;
      cpu_start_addr        <= 22'h00_0000;
      cpu_resume            <= 1'b0;
      cpu_step_inst         <= 1'b0;
      cpu_step_bus          <= 1'b0;
      dma_grant_transfers   <= 1'b1;
      mmu_req               <= 1'b0;
      mmu_vaddr             <= 16'h0000;
      mmu_mode_space        <= 3'h0;
      mem_req               <= 1'b0;
      mem_wr                <= 1'b0;
      mem_addr              <= 22'h00_0000;
      mem_wdata             <= 16'h0000;
      reg_req               <= 1'b0;
      reg_wr                <= 1'b0;
      reg_index             <= 4'h0;
      reg_wdata             <= 16'h0000;
    end else begin
      sys_clear     <= 1'b0;
      cpu_start     <= 1'b0;
      cpu_resume    <= 1'b0;
      cpu_step_inst <= 1'b0;
      cpu_step_bus  <= 1'b0;
      // lever level alone halts; returning to enable starts nothing
      cpu_halt_req        <= halt_lvl;
      dma_grant_transfers <= !(halt_lvl && bus_step);
      // the view selector picks what the address lamps show, the load width and the mmu or physical access path
      addr_display <= (sel_s2 == `FPC_SEL_XLAT) ? xlat_addr : addr_reg;
      case (state)
        S_IDLE: begin
          if (p_start && !cpu_running) begin
            sys_clear <= 1'b1;
            last_op   <= `FPC_NONE;
            if (!halt_lvl) begin
              state <= S_START;
            end
          end else if (p_res && !cpu_running) begin
            if (!halt_lvl) begin
              cpu_resume <= 1'b1;
            end else if (bus_step) begin
              cpu_step_bus <= 1'b1;
            end else begin
              cpu_step_inst <= 1'b1;
            end
          end else if (p_load) begin
            // a fresh load is the only way out of a fault
            addr_reg <= (sel_s2 < `FPC_SEL_XLAT) ?
                        {6'h00, sw_s2[15:0]} : sw_s2;
            fault                 <= 1'b0;
            addressing_fault_lamp <= 1'b0;
            parity_fault_lamp     <= 1'b0;
            last_op               <= `FPC_NONE;
          end else if ((p_read || p_write) && !fault) begin
            addr_reg <= acc_addr;
            cur_wr   <= p_write;
            last_op  <= p_write ? `FPC_WRITE : `FPC_READ;
            last_reg <= is_greg(acc_addr);
            if (is_greg(acc_addr)) begin
              state     <= S_REG;
              reg_req   <= 1'b1;
              reg_wr    <= p_write;
              reg_index <= acc_addr[3:0];
              reg_wdata <= sw_s2[15:0];
            end else if (sel_s2 < `FPC_SEL_XLAT) begin
              state          <= S_MMU;
              mmu_req        <= 1'b1;
              mmu_vaddr      <= acc_addr[15:0];
              mmu_mode_space <= sel_s2;
            end else begin
              state     <= S_MEM;
              mem_req   <= 1'b1;
              mem_wr    <= p_write;
              mem_addr  <= acc_addr;
              mem_wdata <= sw_s2[15:0];
            end
          end
        end
        S_START: begin
          // run begins the cycle after the clear pulse
          cpu_start      <= 1'b1;
          cpu_start_addr <= addr_reg;
          state          <= S_IDLE;
        end
        S_MMU: begin
          if (mmu_ack) begin
            mmu_req <= 1'b0;
            if (mmu_fault) begin
              fault                 <= 1'b1;
              addressing_fault_lamp <= 1'b1;
              state                 <= S_IDLE;
            end else begin
              xlat_addr <= mmu_paddr;
              state     <= S_MEM;
              mem_req   <= 1'b1;
              mem_wr    <= cur_wr;
              mem_addr  <= mmu_paddr;
              mem_wdata <= sw_s2[15:0];
            end
          end
        end
        S_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            state   <= S_IDLE;
            if (mem_addr_fault || mem_parity_fault) begin
              fault                 <= 1'b1;
              addressing_fault_lamp <= mem_addr_fault;
              parity_fault_lamp     <= mem_parity_fault;
            end else begin
              data_display <= cur_wr ? mem_wdata : mem_rdata;
            end
          end
        end
        S_REG: begin
          if (reg_ack) begin
            reg_req      <= 1'b0;
            state        <= S_IDLE;
            data_display <= cur_wr ? reg_wdata : reg_rdata;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fpc_console

/* File: verilog/fpc_consts.vh */
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
// ==========================================================
// timing
`define FPC_CLK_MHZ       100
`define FPC_DEBOUNCE_US   1000
// ==========================================================
// console addressing
`define FPC_GREG_BASE     22'h3F_FFC0
`define FPC_GREG_HI       17:4
`define FPC_GREG_TAG      18'h3_FFFC
`define FPC_MEM_STEP      16'h0002
`define FPC_GREG_STEP     4'h1
`define FPC_BLOCK_HI      21:16
`define FPC_SEL_XLAT      3'h6
`define FPC_SEL_PHYS      3'h7
// ==========================================================
// apb register map
`define FPC_OFF_CTRL      12'h000
`define FPC_OFF_STATUS    12'h004
`define FPC_OFF_ADDR      12'h008
`define FPC_OFF_DATA      12'h00C
`define FPC_CTRL_KEYOFF   0
`define FPC_ST_RUN        0
`define FPC_ST_FAULT      1
`define FPC_ST_LREAD      2
`define FPC_ST_LWRITE     3
`define FPC_ST_LREG       4
`define FPC_ST_BUSY       5
`define FPC_ST_HALT       6
`define FPC_ZERO32        32'h0000_0000
`define FPC_NONE          2'h0
`define FPC_READ          2'h1
`define FPC_WRITE         2'h2
`endif
